// File: sim/doad_scanner.sv
`timescale 1ns/1ps
module doad_scanner (
  // Clock
  input wire logic aclk,
  // Byte stream to the device
  output logic pd_valid,
  input wire logic pd_ready,
  output logic [7:0] pd_data,
  output logic pd_last,
  output logic [31:0] pd_src_ip
);
  initial begin
    pd_valid = 0;
    pd_data = 8'h00;
    pd_last = 0;
    pd_src_ip = 32'h0;
  end
  task automatic send(input logic [7:0] b[$], input logic [31:0] ip);
    foreach (b[i]) begin
      pd_valid <= 1;
      pd_data <= b[i];
      pd_last <= (i == b.size() - 1);
      pd_src_ip <= ip;
      do @(posedge aclk); while (!pd_ready);
    end
    pd_valid <= 0;
    pd_last <= 0;
    pd_data <= ~pd_data;
  endtask
endmodule // doad_scanner

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import doad_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, ent_ready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pd_data;
  logic [31:0] wdata = 32'h0, rdata, d, pd_src_ip, ent_value;
  logic [3:0] wstrb = 4'hf, ent_sel;
  logic awready, wready, bvalid, arready, rvalid, pd_valid, pd_ready, pd_last;
  logic [1:0] bresp, rresp;
  logic run_fwd, run_rev, fault_reset, network_control_select, network_reference_select;
  logic [15:0] speed_ref, torque_ref, ent_index;
  logic ref_update, frame_refused, conn_open, ent_wr;
  logic [15:0] sel [4] = '{16'h0005, 16'h0005, 16'h03e8, 16'h0bb8};
  logic [51:0] cap [$];
  int errors = 0, checks_done = 0, cyc = 0;
  doad_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pd_valid, .pd_ready, .pd_data, .pd_last, .pd_src_ip, .run_fwd, .run_rev,
    .fault_reset, .network_control_select, .network_reference_select, .speed_ref,
    .torque_ref, .ref_update, .frame_refused, .conn_open, .ent_wr, .ent_sel, .ent_index,
    .ent_value, .ent_ready);
  doad_scanner i_scan (.aclk, .pd_valid, .pd_ready, .pd_data, .pd_last, .pd_src_ip);
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Entry consumer stalls every other cycle
  always @(posedge aclk) begin
    ent_ready <= ~ent_ready;
    if (ent_wr && ent_ready) cap.push_back({ent_sel, ent_index, ent_value});
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task chk(input logic [63:0] s, input logic [63:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do @(posedge aclk); while (!awready);
    awvalid <= 0;
    wvalid <= 0;
    do @(posedge aclk); while (!bvalid);
    chk(bresp, r, "bresp");
    bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    chk(rresp, r, "rresp");
    rready <= 0;
    @(posedge aclk);
  endtask
  task wait_done;
    int n;
    n = 0;
    do @(posedge aclk); while (!(ref_update || frame_refused) && ++n < 40);
    if (n >= 40) begin
      errors++;
      summarize();
    end else begin
      @(posedge aclk);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(A_CLASS_REV, RESP_OKAY);
    chk(d, 32'h2, "revision");
    rd(A_MAX_INST, RESP_OKAY);
    chk(d, 32'h96, "max instance");
    wr(A_CLASS_REV, 32'h7, RESP_SLVERR);
    rd(A_CLASS_REV, RESP_OKAY);
    chk(d, 32'h2, "revision kept");
    rd(8'hfc, RESP_SLVERR);
    $display("registers done");
    wr(A_CTRL, 32'h114, RESP_OKAY);
    i_scan.send('{8'hff, 8'hff, 8'h34, 8'h12}, 32'h0);
    wait_done();
    chk({run_fwd, run_rev, fault_reset, network_control_select,
         network_reference_select, speed_ref}, {5'b10100, 16'h1234}, "inst20");
    $display("basic layout done");
    wr(A_CTRL, 32'h117, RESP_OKAY);
    i_scan.send('{8'hff, 8'h00, 8'hcd, 8'hab, 8'h78, 8'h56}, 32'h0);
    wait_done();
    chk({run_fwd, run_rev, fault_reset, network_control_select,
         network_reference_select}, 5'b11111, "inst23 bits");
    i_scan.send('{8'h00, 8'h00, 8'h11, 8'h22}, 32'h0);
    wait_done();
    rd(A_REFS, RESP_OKAY);
    chk(d, 32'h5678abcd, "inst23 refs");
    wr(A_CTRL, 32'h115, RESP_OKAY);
    i_scan.send('{8'hfa, 8'hff, 8'h02, 8'h01}, 32'h0);
    wait_done();
    chk({run_fwd, run_rev, fault_reset, network_control_select,
         network_reference_select, speed_ref}, {5'b01011, 16'h0102}, "inst21");
    wr(A_CTRL, 32'h116, RESP_OKAY);
    i_scan.send('{8'hff, 8'h00, 8'h22, 8'h11, 8'h44, 8'h33}, 32'h0);
    wait_done();
    chk({run_fwd, run_rev, fault_reset, network_control_select, network_reference_select,
         speed_ref, torque_ref}, {5'b10100, 16'h1122, 16'h3344}, "inst22");
    $display("extended layout done");
    wr(A_CMD_IP, 32'h0a000001, RESP_OKAY);
    i_scan.send('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 32'h0a000002);
    wait_done();
    chk(run_fwd, 1'b1, "foreign source ignored");
    i_scan.send('{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 32'h0a000001);
    wait_done();
    chk({run_rev, fault_reset, speed_ref}, 18'h0, "own source");
    rd(A_STATUS, RESP_OKAY);
    chk({d[17:2], d[0]}, {8'h2, 8'h5, 1'b1}, "frame counts");
    $display("command source done");
    wr(A_FIXED_FMT, 32'h270f, RESP_OKAY);
    wr(A_CTRL, 32'h164, RESP_OKAY);
    rd(A_STATUS, RESP_OKAY);
    chk({conn_open, d[1:0]}, 3'b010, "all empty refused");
    for (int k = 0; k < 4; k++) wr(8'(32 + 4 * k), 32'(sel[k]), RESP_OKAY);
    rd(A_LAYOUT, RESP_OKAY);
    chk({conn_open, d}, {1'b1, 32'h8}, "layout length");
    i_scan.send('{8'h11, 8'h22, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6}, 32'h0a000001);
    wait_done();
    chk(cap.size(), 36'h2, "entry count");
    chk(cap[0], {4'h0, 16'h0005, 32'h2211}, "entry 0");
    chk(cap[1], {4'h2, 16'h03e8, 32'hd4c3b2a1}, "entry 2");
    wr(A_FIXED_FMT, 32'h6, RESP_OKAY);
    rd(A_LAYOUT, RESP_OKAY);
    chk(d, 32'he, "six byte fixed field");
    $display("configurable layout done");
    summarize();
  end
endmodule // tb_top

// File: verilog/doad_fifo.sv
`timescale 1ns/1ps
module doad_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic ready_ff, nxt_ready;
  logic push, pop;

  assign in_ready = ready_ff;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rd_ff];

  always_comb begin
    push = in_valid && ready_ff;
    pop = out_ready && (cnt_ff != '0);
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = wr_ff + AW'(1);
    end
    if (pop) begin
      nxt_rd = rd_ff + AW'(1);
    end
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
    nxt_ready = nxt_cnt != CW'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      ready_ff <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      mem_ff <= nxt_mem;
    end
  end
endmodule // doad_fifo

// File: verilog/doad_layout.sv
`timescale 1ns/1ps
module doad_layout (
  // Layout settings and results
  doad_layout_if.calc lay
);
  import doad_pkg::*;
  logic [POS_W-1:0] pos;
  logic dup;
  logic none;

  always_comb begin
    if (lay.fix_sel == SEL_NONE) begin
      lay.fix_len = 3'h0;
    end else if (lay.fix_sel == FIX_SIX) begin
      lay.fix_len = LEN_SIX;
    end else begin
      lay.fix_len = LEN_FOUR;
    end
    pos = POS_W'(lay.fix_len);
    lay.all_none = lay.fix_sel == SEL_NONE;
    for (int e = 0; e < NUM_ENT; e++) begin
      dup = 1'b0;
      for (int j = 0; j < NUM_ENT; j++) begin
        if (j < e && lay.ent_idx[j] == lay.ent_idx[e]) begin
          dup = 1'b1;
        end
      end
      none = (lay.ent_idx[e] == SEL_NONE) || dup;
      lay.all_none = lay.all_none && (lay.ent_idx[e] == SEL_NONE);
      lay.ent_exist[e] = !none && idx_exists(lay.ent_idx[e]);
      lay.ent_len[e] = none ? 3'h0 : entry_size(lay.ent_idx[e]);
      lay.ent_start[e] = pos;
      pos = pos + POS_W'(lay.ent_len[e]);
    end
    lay.total_len = pos;
  end
endmodule // doad_layout

// File: verilog/doad_layout_if.sv
`timescale 1ns/1ps
interface doad_layout_if;
  import doad_pkg::*;
  logic [15:0] fix_sel;
  logic [15:0] ent_idx [NUM_ENT];
  logic [2:0] fix_len;
  logic [2:0] ent_len [NUM_ENT];
  logic [POS_W-1:0] ent_start [NUM_ENT];
  logic [NUM_ENT-1:0] ent_exist;
  logic [POS_W-1:0] total_len;
  logic all_none;
  modport calc (input fix_sel, ent_idx,
                output fix_len, ent_len, ent_start, ent_exist, total_len, all_none);
  modport user (output fix_sel, ent_idx,
                input fix_len, ent_len, ent_start, ent_exist, total_len, all_none);
endinterface

// File: verilog/doad_pkg.sv
package doad_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_ENT = 10;
  localparam int POS_W = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 41;
  localparam int FD_LAST = 8;
  localparam int FD_IP_LSB = 9;
  // Register byte addresses
  localparam logic [7:0] A_CLASS_REV = 8'h00;
  localparam logic [7:0] A_MAX_INST = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_FIXED_FMT = 8'h10;
  localparam logic [7:0] A_CMD_IP = 8'h14;
  localparam logic [7:0] A_LAYOUT = 8'h18;
  localparam logic [7:0] A_REFS = 8'h1c;
  localparam logic [7:0] A_ENTRY0 = 8'h20;
  localparam logic [7:0] A_ENTRY_END = 8'h48;
  localparam logic [15:0] CLASS_REV = 16'h0002;
  localparam logic [15:0] MAX_INST = 16'h0096;
  // Instance numbers
  localparam logic [7:0] INST_BASIC = 8'h14;
  localparam logic [7:0] INST_EXT = 8'h15;
  localparam logic [7:0] INST_ST = 8'h16;
  localparam logic [7:0] INST_EXT_ST = 8'h17;
  localparam logic [7:0] INST_CFG_OUT = 8'h64;
  // Control register: instance in [7:0], connect request in bit 8
  localparam int CTRL_REQ_BIT = 8;
  localparam logic [8:0] CTRL_RST = 9'h014;
  localparam logic [15:0] FIX_RST = 16'h0004;
  localparam logic [31:0] CMD_IP_RST = 32'h0;
  localparam logic [15:0] SEL_NONE = 16'h270f;
  localparam logic [15:0] FIX_SIX = 16'h0006;
  localparam logic [2:0] LEN_FOUR = 3'h4;
  localparam logic [2:0] LEN_SIX = 3'h6;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  // Index classes decide entry data width
  localparam logic [15:0] IDX_4B_LO = 16'h03e8;
  localparam logic [15:0] IDX_1B_LO = 16'h07d0;
  localparam logic [15:0] IDX_EXIST_MAX = 16'h0bb7;
  // Control byte bits and masks
  localparam int B_RUN_FWD = 0;
  localparam int B_RUN_REV = 1;
  localparam int B_FAULT_RST = 2;
  localparam int B_NET_CTRL = 5;
  localparam int B_NET_REF = 6;
  localparam logic [7:0] MASK_BASIC = 8'h05;
  localparam logic [7:0] MASK_EXT = 8'h67;
  localparam logic [POS_W-1:0] POS_CTL = 6'h0;
  localparam logic [POS_W-1:0] POS_SP_LO = 6'h2;
  localparam logic [POS_W-1:0] POS_SP_HI = 6'h3;
  localparam logic [POS_W-1:0] POS_TQ_LO = 6'h4;
  localparam logic [POS_W-1:0] POS_TQ_HI = 6'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DOAD_IDLE = 2'h0,
    DOAD_RECV = 2'h1,
    DOAD_DROP = 2'h3
  } doad_state_t;

  function automatic logic [31:0] wr_strb(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wr_strb[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic idx_exists(input logic [15:0] idx);
    idx_exists = idx <= IDX_EXIST_MAX;
  endfunction

  function automatic logic [2:0] entry_size(input logic [15:0] idx);
    if (idx >= IDX_1B_LO && idx <= IDX_EXIST_MAX) begin
      entry_size = LEN_ONE;
    end else if (idx >= IDX_4B_LO && idx < IDX_1B_LO) begin
      entry_size = LEN_FOUR;
    end else begin
      entry_size = LEN_TWO;
    end
  endfunction
endpackage

// File: verilog/doad_top.sv
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module doad_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [doad_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [doad_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [doad_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [doad_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Process data byte stream
  input wire logic pd_valid,
  output logic pd_ready,
  input wire logic [7:0] pd_data,
  input wire logic pd_last,
  input wire logic [31:0] pd_src_ip,
  // Drive commands
  output logic run_fwd,
  output logic run_rev,
  output logic fault_reset,
  output logic network_control_select,
  output logic network_reference_select,
  output logic [15:0] speed_ref,
  output logic [15:0] torque_ref,
  output logic ref_update,
  output logic frame_refused,
  output logic conn_open,
  // Configurable entry writes
  output logic ent_wr,
  output logic [3:0] ent_sel,
  output logic [15:0] ent_index,
  output logic [31:0] ent_value,
  input wire logic ent_ready
);
  import doad_pkg::*;

  logic awready_ff, nxt_awready, arready_ff, nxt_arready;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [8:0] ctrl_ff, nxt_ctrl;
  logic [15:0] fix_ff, nxt_fix;
  logic [31:0] cmd_ip_ff, nxt_cmd_ip;
  logic [15:0] ent_idx_ff [NUM_ENT];
  logic [15:0] nxt_ent_idx [NUM_ENT];
  doad_state_t state_ff, nxt_state;
  logic [POS_W-1:0] pos_ff, nxt_pos, p, flen, exp_len;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [15:0] sp_ff, nxt_sp, tq_ff, nxt_tq;
  logic [31:0] acc_ff, nxt_acc;
  logic [7:0] out_bits_ff, nxt_out_bits;
  logic [15:0] speed_ff, nxt_speed, torque_ff, nxt_torque;
  logic upd_ff, nxt_upd, refused_ff, nxt_refused, open_ff, nxt_open;
  logic cfg_refused_ff, nxt_cfg_refused;
  logic [7:0] ok_cnt_ff, nxt_ok_cnt, bad_cnt_ff, nxt_bad_cnt;
  logic ent_wr_ff, nxt_ent_wr;
  logic [3:0] ent_sel_ff, nxt_ent_sel;
  logic [15:0] ent_index_ff, nxt_ent_index;
  logic [31:0] ent_value_ff, nxt_ent_value;
  logic f_valid, f_ready, pop, recv, src_ok, ext, has_tq, is_cfg;
  logic [FIFO_W-1:0] f_data;
  logic [7:0] act_inst, byte_in;
  logic [1:0] b;

  function automatic logic is_ent_addr(input logic [7:0] a);
    is_ent_addr = a >= A_ENTRY0 && a < A_ENTRY_END && a[1:0] == 2'h0;
  endfunction

  function automatic logic [3:0] ent_num(input logic [7:0] a);
    logic [7:0] d;
    d = a - A_ENTRY0;
    ent_num = d[5:2];
  endfunction

  function automatic logic is_output_inst(input logic [7:0] inst);
    is_output_inst = (inst >= INST_BASIC && inst <= INST_EXT_ST) || inst == INST_CFG_OUT;
  endfunction

  doad_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .in_valid(pd_valid),
    .in_ready(pd_ready),
    .in_data({pd_src_ip, pd_last, pd_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  doad_layout_if lay ();
  assign lay.fix_sel = fix_ff;
  assign lay.ent_idx = ent_idx_ff;
  doad_layout u_layout (.lay(lay.calc));

  assign awready = awready_ff;
  assign wready = awready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign run_fwd = out_bits_ff[B_RUN_FWD];
  assign run_rev = out_bits_ff[B_RUN_REV];
  assign fault_reset = out_bits_ff[B_FAULT_RST];
  assign network_control_select = out_bits_ff[B_NET_CTRL];
  assign network_reference_select = out_bits_ff[B_NET_REF];
  assign speed_ref = speed_ff;
  assign torque_ref = torque_ff;
  assign ref_update = upd_ff;
  assign frame_refused = refused_ff;
  assign conn_open = open_ff;
  assign ent_wr = ent_wr_ff;
  assign ent_sel = ent_sel_ff;
  assign ent_index = ent_index_ff;
  assign ent_value = ent_value_ff;

  // Register slave
  always_comb begin
    nxt_awready = awvalid && wvalid && !awready_ff && !bvalid_ff;
    nxt_arready = arvalid && !arready_ff && !rvalid_ff;
    nxt_bvalid = bvalid_ff && !bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_fix = fix_ff;
    nxt_cmd_ip = cmd_ip_ff;
    nxt_ent_idx = ent_idx_ff;
    if (awready_ff) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (awaddr == A_CTRL) begin
        nxt_ctrl = 9'(wr_strb({23'h0, ctrl_ff}, wdata, wstrb));
      end else if (awaddr == A_FIXED_FMT) begin
        nxt_fix = 16'(wr_strb({16'h0, fix_ff}, wdata, wstrb));
      end else if (awaddr == A_CMD_IP) begin
        nxt_cmd_ip = wr_strb(cmd_ip_ff, wdata, wstrb);
      end else if (is_ent_addr(awaddr)) begin
        nxt_ent_idx[ent_num(awaddr)] =
          16'(wr_strb({16'h0, ent_idx_ff[ent_num(awaddr)]}, wdata, wstrb));
      end else begin
        nxt_bresp = RESP_SLVERR;
      end
    end
    if (arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (araddr)
        A_CLASS_REV: nxt_rdata = {16'h0, CLASS_REV};
        A_MAX_INST: nxt_rdata = {16'h0, MAX_INST};
        A_CTRL: nxt_rdata = {23'h0, ctrl_ff};
        A_STATUS: nxt_rdata = {14'h0, bad_cnt_ff, ok_cnt_ff, cfg_refused_ff, open_ff};
        A_FIXED_FMT: nxt_rdata = {16'h0, fix_ff};
        A_CMD_IP: nxt_rdata = cmd_ip_ff;
        A_LAYOUT: nxt_rdata = {26'h0, lay.total_len};
        A_REFS: nxt_rdata = {torque_ff, speed_ff};
        default: begin
          if (is_ent_addr(araddr)) begin
            nxt_rdata = {16'h0, ent_idx_ff[ent_num(araddr)]};
          end else begin
            nxt_rdata = 32'h0;
            nxt_rresp = RESP_SLVERR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0;
      ctrl_ff <= CTRL_RST;
      fix_ff <= FIX_RST;
      cmd_ip_ff <= CMD_IP_RST;
      for (int i = 0; i < NUM_ENT; i++) begin
        ent_idx_ff[i] <= SEL_NONE;
      end
    end else begin
      awready_ff <= nxt_awready;
      arready_ff <= nxt_arready;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      fix_ff <= nxt_fix;
      cmd_ip_ff <= nxt_cmd_ip;
      ent_idx_ff <= nxt_ent_idx;
    end
  end

  // Frame decoder; stalls while an entry write waits
  assign f_ready = !ent_wr_ff || ent_ready;
  assign pop = f_valid && f_ready;
  assign byte_in = f_data[7:0];
  assign act_inst = ctrl_ff[7:0];
  assign is_cfg = act_inst == INST_CFG_OUT;
  assign src_ok = cmd_ip_ff == CMD_IP_RST || f_data[FD_IP_LSB +: 32] == cmd_ip_ff;
  assign ext = act_inst == INST_EXT || act_inst == INST_EXT_ST || is_cfg;
  assign flen = is_cfg ? POS_W'(lay.fix_len) :
                (act_inst >= INST_ST ? POS_W'(LEN_SIX) : POS_W'(LEN_FOUR));
  assign has_tq = flen == POS_W'(LEN_SIX);
  assign exp_len = is_cfg ? lay.total_len : flen;

  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    nxt_ctl = ctl_ff;
    nxt_sp = sp_ff;
    nxt_tq = tq_ff;
    nxt_acc = acc_ff;
    nxt_out_bits = out_bits_ff;
    nxt_speed = speed_ff;
    nxt_torque = torque_ff;
    nxt_upd = 1'b0;
    nxt_refused = 1'b0;
    nxt_ok_cnt = ok_cnt_ff;
    nxt_bad_cnt = bad_cnt_ff;
    nxt_ent_wr = ent_wr_ff && !ent_ready;
    nxt_ent_sel = ent_sel_ff;
    nxt_ent_index = ent_index_ff;
    nxt_ent_value = ent_value_ff;
    b = 2'h0;
    nxt_open = ctrl_ff[CTRL_REQ_BIT] && is_output_inst(act_inst) && !(is_cfg && lay.all_none);
    nxt_cfg_refused = ctrl_ff[CTRL_REQ_BIT] && !nxt_open;
    p = pos_ff;
    unique case (state_ff)
      DOAD_IDLE: begin
        p = '0;
        recv = open_ff && src_ok;
      end
      DOAD_RECV: recv = 1'b1;
      DOAD_DROP: recv = 1'b0;
      default: recv = 1'b0;
    endcase
    if (pop) begin
      nxt_state = recv ? DOAD_RECV : DOAD_DROP;
      nxt_pos = p + POS_W'(1);
      if (recv && p < flen) begin
        case (p)
          POS_CTL: nxt_ctl = byte_in & (ext ? MASK_EXT : MASK_BASIC);
          POS_SP_LO: nxt_sp[7:0] = byte_in;
          POS_SP_HI: nxt_sp[15:8] = byte_in;
          POS_TQ_LO: nxt_tq[7:0] = byte_in;
          POS_TQ_HI: nxt_tq[15:8] = byte_in;
          default: nxt_ctl = ctl_ff;
        endcase
      end else if (recv && is_cfg) begin
        for (int e = 0; e < NUM_ENT; e++) begin
          if (p >= lay.ent_start[e] && p < lay.ent_start[e] + POS_W'(lay.ent_len[e])) begin
            b = 2'(p - lay.ent_start[e]);
            if (b == 2'h0) begin
              nxt_acc = {24'h0, byte_in};
            end else begin
              nxt_acc[8*b +: 8] = byte_in;
            end
            if (3'(b) == lay.ent_len[e] - 3'h1 && lay.ent_exist[e]) begin
              nxt_ent_wr = 1'b1;
              nxt_ent_sel = 4'(e);
              nxt_ent_index = lay.ent_idx[e];
              nxt_ent_value = nxt_acc;
            end
          end
        end
      end
      if (f_data[FD_LAST]) begin
        nxt_state = DOAD_IDLE;
        nxt_pos = '0;
        if (recv && p == exp_len - POS_W'(1)) begin
          if (flen != '0) begin
            nxt_out_bits = nxt_ctl;
            nxt_speed = nxt_sp;
            nxt_torque = has_tq ? nxt_tq : torque_ff;
          end
          nxt_upd = 1'b1;
          nxt_ok_cnt = ok_cnt_ff + 8'h1;
        end else begin
          nxt_refused = 1'b1;
          nxt_bad_cnt = bad_cnt_ff + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= DOAD_IDLE;
      pos_ff <= '0;
      ctl_ff <= 8'h0;
      sp_ff <= 16'h0;
      tq_ff <= 16'h0;
      acc_ff <= 32'h0;
      out_bits_ff <= 8'h0;
      speed_ff <= 16'h0;
      torque_ff <= 16'h0;
      upd_ff <= 1'b0;
      refused_ff <= 1'b0;
      open_ff <= 1'b0;
      cfg_refused_ff <= 1'b0;
      ok_cnt_ff <= 8'h0;
      bad_cnt_ff <= 8'h0;
      ent_wr_ff <= 1'b0;
      ent_sel_ff <= 4'h0;
      ent_index_ff <= 16'h0;
      ent_value_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      ctl_ff <= nxt_ctl;
      sp_ff <= nxt_sp;
      tq_ff <= nxt_tq;
      acc_ff <= nxt_acc;
      out_bits_ff <= nxt_out_bits;
      speed_ff <= nxt_speed;
      torque_ff <= nxt_torque;
      upd_ff <= nxt_upd;
      refused_ff <= nxt_refused;
      open_ff <= nxt_open;
      cfg_refused_ff <= nxt_cfg_refused;
      ok_cnt_ff <= nxt_ok_cnt;
      bad_cnt_ff <= nxt_bad_cnt;
      ent_wr_ff <= nxt_ent_wr;
      ent_sel_ff <= nxt_ent_sel;
      ent_index_ff <= nxt_ent_index;
      ent_value_ff <= nxt_ent_value;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd_take(logic [7:0] a);
    arready_ff && araddr == a;
  endsequence
  sequence s_first_bad;
    pop && state_ff == DOAD_IDLE && open_ff && !src_ok;
  endsequence

  AST_CLASS_REV: assert property (s_rd_take(A_CLASS_REV) |=> rvalid_ff && rdata_ff == 32'h2)
    else $error("class revision read wrong");
  AST_MAX_INST: assert property (s_rd_take(A_MAX_INST) |=> rdata_ff == 32'h96)
    else $error("highest instance read wrong");
  AST_SRC_REFUSE: assert property (s_first_bad |=> !upd_ff &&
    (refused_ff || state_ff == DOAD_DROP)) else $error("foreign source frame accepted");
  AST_INST20_BITS: assert property (upd_ff && act_inst == INST_BASIC |->
    !run_rev && !network_control_select && !network_reference_select)
    else $error("basic layout set extended bit");
  AST_INST21_LEN: assert property (upd_ff && act_inst == INST_EXT |->
    $past(pos_ff) == 6'h3) else $error("extended frame not four bytes");
  AST_INST22_LEN: assert property (upd_ff && act_inst == INST_ST |->
    $past(pos_ff) == 6'h5) else $error("speed torque frame not six bytes");
  AST_INST23_TQ: assert property (upd_ff && act_inst == INST_EXT_ST |->
    torque_ff == $past(nxt_tq))
    else $error("torque not taken from frame");
  AST_ALL_NONE: assert property (open_ff |-> !$past(is_cfg && lay.all_none))
    else $error("connection open with empty layout");
  AST_NO_NONEXIST: assert property ($rose(ent_wr_ff) |->
    idx_exists(ent_index_ff) && ent_index_ff != SEL_NONE)
    else $error("entry write for missing index");
  AST_ENT_HOLD: assert property (ent_wr_ff && !ent_ready |=>
    ent_wr_ff && $stable(ent_value_ff) && $stable(ent_sel_ff))
    else $error("entry write dropped before taken");
  AST_BRESP: assert property (awready_ff |=> bvalid_ff)
    else $error("write response missing");
endmodule // doad_top
